// File: sbsi_core.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Target drives low-active request per transfer.
// - Initiator answers each request with acknowledge.
// - Received request/acknowledge pace transfer steps.
// - Initiator drives attention low for message.
// - Message line low only in message phases.
// - Control/data low in command, status, message.
// - Direction low means target to initiator.
// - Busy low marks occupied bus, arbitration.
// - Select low during selection and reselection.
// - Drive bus reset out, accept it in.
// - Separate enables for busy, select, reset.
// - Two bytes, each with odd parity.
// - Enable output per data and parity bit.
// - Role flags: none, target or initiator.
// - Each word moved by interlocked handshake.
module sbsi_core
  import sbsi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  // User side.
  input wire logic arbitrate,
  input wire logic selectStart,
  input wire logic connectTarget,
  input wire logic connectInit,
  input wire logic disconnect,
  input wire logic busResetReq,
  input wire logic attentionReq,
  input wire logic [2:0] phaseReq,
  input wire logic wordSend,
  input wire logic [15:0] wordOut,
  output logic wordReady,
  output logic wordDone,
  output logic [15:0] wordIn,
  output logic busResetSeen,
  output logic modeDifferential,
  // Bus side, active-low levels.
  input wire logic reqIn,
  input wire logic ackIn,
  input wire logic atnIn,
  input wire logic [2:0] phaseIn,
  input wire logic bsyIn,
  input wire logic selIn,
  input wire logic rstIn,
  input wire logic [15:0] dataBusIn,
  input wire logic transmission_mode_select,
  output logic reqOut,
  output logic reqOe,
  output logic ackOut,
  output logic ackOe,
  output logic atnOut,
  output logic atnOe,
  output logic [2:0] phaseOut,
  output logic phaseOe,
  output logic bsyOut,
  output logic busy_drive_enable,
  output logic selOut,
  output logic select_drive_enable,
  output logic rstOut,
  output logic bus_reset_drive_enable,
  output logic [15:0] dataBusOut,
  output logic upper_byte_parity,
  output logic lower_byte_parity,
  output logic [15:0] data_bit_drive_enable,
  output logic upper_parity_drive_enable,
  output logic lower_parity_drive_enable,
  output logic initiator_role_flag,
  output logic target_role_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  typedef struct packed {
    sbsi_role_t role;
    sbsi_hs_t hs;
    logic bsy;
    logic sel;
    logic rstDrv;
    logic atn;
    logic [2:0] phase;
    logic strobe;
    logic done;
    logic [15:0] rx;
  } sbsi_state_t;

  sbsi_state_t st_reg;
  sbsi_state_t st_next;

  logic isTarget;
  logic isInit;
  logic sending;
  logic loadLanes;
  logic releaseLanes;
  logic [8:0] upperEn;
  logic [8:0] lowerEn;

  assign isTarget = (st_reg.role == SBSI_ROLE_TARGET_ROLE_FLAG);
  assign isInit = (st_reg.role == SBSI_ROLE_INIT);
  // Data flows out when the direction bit says so for our role.
  assign sending = isTarget ? (st_reg.phase[SBSI_PH_IO_BIT] == 1'h0)
                 : (phaseIn[SBSI_PH_IO_BIT] == 1'h1);
  assign wordReady = (st_reg.hs == SBSI_HS_IDLE) && (isTarget || isInit);
  assign loadLanes = wordReady && wordSend && sending;
  assign releaseLanes = (st_reg.hs == SBSI_HS_IDLE) && !loadLanes;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Role, control lines and the interlocked handshake.
  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'h0;
    st_next.rstDrv = busResetReq;
    st_next.bsy = arbitrate || (st_reg.role != SBSI_ROLE_NONE);
    st_next.sel = selectStart;
    st_next.atn = isInit && attentionReq;
    if (isTarget)
    begin
      st_next.phase = phaseReq;
    end
    if (disconnect || rstIn == SBSI_ASSERTED)
    begin
      st_next.role = SBSI_ROLE_NONE;
      st_next.hs = SBSI_HS_IDLE;
      st_next.strobe = 1'h0;
    end
    else
    begin
      if (connectTarget)
      begin
        st_next.role = SBSI_ROLE_TARGET_ROLE_FLAG;
      end
      else if (connectInit)
      begin
        st_next.role = SBSI_ROLE_INIT;
      end
      case (st_reg.hs)
        SBSI_HS_IDLE:
        begin
          if (isTarget && wordSend)
          begin
            st_next.strobe = 1'h1;
            st_next.hs = SBSI_HS_WAIT_ASSERT;
          end
          else if (isInit && reqIn == SBSI_ASSERTED)
          begin
            st_next.hs = SBSI_HS_WAIT_ASSERT;
          end
        end
        SBSI_HS_WAIT_ASSERT:
        begin
          if (isTarget && ackIn == SBSI_ASSERTED)
          begin
            if (!sending)
            begin
              st_next.rx = ~dataBusIn;
            end
            st_next.strobe = 1'h0;
            st_next.hs = SBSI_HS_WAIT_NEGATE;
          end
          else if (isInit && (wordSend || !sending))
          begin
            if (!sending)
            begin
              st_next.rx = ~dataBusIn;
            end
            st_next.strobe = 1'h1;
            st_next.hs = SBSI_HS_WAIT_NEGATE;
          end
        end
        SBSI_HS_WAIT_NEGATE:
        begin
          if (isTarget && ackIn == SBSI_RELEASED)
          begin
            st_next.hs = SBSI_HS_IDLE;
            st_next.done = 1'h1;
          end
          else if (isInit && reqIn == SBSI_RELEASED)
          begin
            st_next.strobe = 1'h0;
            st_next.hs = SBSI_HS_IDLE;
            st_next.done = 1'h1;
          end
        end
        default:
        begin
          st_next.hs = SBSI_HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Data lanes
  // ----------------------------------------------------------------

  // Upper and lower byte each carry their own parity.
  sbsi_byte_lane upperLane (
    .core_clk(core_clk),
    .rst(rst),
    .load(loadLanes),
    .release_lane(releaseLanes),
    .byteIn(wordOut[SBSI_DATA_W-1:SBSI_BYTE_W]),
    .busByte(dataBusOut[SBSI_DATA_W-1:SBSI_BYTE_W]),
    .busParity(upper_byte_parity),
    .driveEnable(upperEn)
  );

  sbsi_byte_lane lowerLane (
    .core_clk(core_clk),
    .rst(rst),
    .load(loadLanes),
    .release_lane(releaseLanes),
    .byteIn(wordOut[SBSI_BYTE_W-1:0]),
    .busByte(dataBusOut[SBSI_BYTE_W-1:0]),
    .busParity(lower_byte_parity),
    .driveEnable(lowerEn)
  );

  assign data_bit_drive_enable = {upperEn[SBSI_BYTE_W-1:0],
                                  lowerEn[SBSI_BYTE_W-1:0]};
  assign upper_parity_drive_enable = upperEn[SBSI_BYTE_W];
  assign lower_parity_drive_enable = lowerEn[SBSI_BYTE_W];

  // ----------------------------------------------------------------
  // Control line outputs
  // ----------------------------------------------------------------

  // Active-low lines; each enable is high exactly while driven.
  assign reqOut = isTarget && st_reg.strobe ? SBSI_ASSERTED : SBSI_RELEASED;
  assign reqOe = isTarget && st_reg.strobe;
  assign ackOut = isInit && st_reg.strobe ? SBSI_ASSERTED : SBSI_RELEASED;
  assign ackOe = isInit && st_reg.strobe;
  assign atnOut = st_reg.atn ? SBSI_ASSERTED : SBSI_RELEASED;
  assign atnOe = st_reg.atn;
  assign phaseOut = isTarget ? st_reg.phase : {3{SBSI_RELEASED}};
  assign phaseOe = isTarget;
  assign bsyOut = st_reg.bsy ? SBSI_ASSERTED : SBSI_RELEASED;
  assign busy_drive_enable = st_reg.bsy;
  assign selOut = st_reg.sel ? SBSI_ASSERTED : SBSI_RELEASED;
  assign select_drive_enable = st_reg.sel;
  assign rstOut = st_reg.rstDrv ? SBSI_ASSERTED : SBSI_RELEASED;
  assign bus_reset_drive_enable = st_reg.rstDrv;
  assign initiator_role_flag = isInit;
  assign target_role_flag = isTarget;
  assign wordDone = st_reg.done;
  assign wordIn = st_reg.rx;
  assign busResetSeen = (rstIn == SBSI_ASSERTED);
  assign modeDifferential = (transmission_mode_select == SBSI_MODE_DIFF);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  sequence reqRaised;
    reqOe && reqOut == SBSI_ASSERTED;
  endsequence

  chk_req_drop_ack: assert property (
    @(posedge core_clk) disable iff (rst)
    (reqRaised and (ackIn == SBSI_ASSERTED) and !disconnect
     and rstIn == SBSI_RELEASED) |=> !reqOe)
    else $error("Request held after acknowledge.");
  chk_role_excl: assert property (
    @(posedge core_clk) disable iff (rst)
    !(initiator_role_flag && target_role_flag))
    else $error("Both role flags high.");
  chk_busy_enable: assert property (
    @(posedge core_clk) disable iff (rst)
    (arbitrate || isInit || isTarget)
      |=> busy_drive_enable && bsyOut == SBSI_ASSERTED)
    else $error("Busy not driven while arbitrating or connected.");
  chk_reset_drive: assert property (
    @(posedge core_clk) disable iff (rst)
    busResetReq |=> rstOut == SBSI_ASSERTED)
    else $error("Bus reset not driven.");
  chk_msg_phase: assert property (
    @(posedge core_clk) disable iff (rst)
    (phaseOe && phaseOut[SBSI_PH_MSG_BIT] == SBSI_ASSERTED)
      |-> phaseOut[SBSI_PH_CD_BIT] == SBSI_ASSERTED)
    else $error("Message phase with data code.");
  chk_ack_only_init: assert property (
    @(posedge core_clk) disable iff (rst)
    ackOe |-> initiator_role_flag)
    else $error("Acknowledge driven outside initiator role.");
  chk_atn_role: assert property (
    @(posedge core_clk) disable iff (rst)
    (attentionReq && isInit && !disconnect) |=> atnOe)
    else $error("Attention not raised.");
  chk_sel_follow: assert property (
    @(posedge core_clk) disable iff (rst)
    selectStart |=> selOut == SBSI_ASSERTED)
    else $error("Select not driven.");
  chk_bus_reset_drop: assert property (
    @(posedge core_clk) disable iff (rst)
    rstIn == SBSI_ASSERTED |=> !initiator_role_flag && !target_role_flag)
    else $error("Role kept through bus reset.");

endmodule
`default_nettype wire

// File: sbsi_pkg.sv
package sbsi_pkg;

  // ----------------------------------------------------------------
  // Bus phases and line levels
  // ----------------------------------------------------------------

  // Phase codes as {message, control/data, direction} line levels.
  localparam logic [2:0] SBSI_PH_DATA_OUT = 3'h7;
  localparam logic [2:0] SBSI_PH_DATA_IN = 3'h6;
  localparam logic [2:0] SBSI_PH_COMMAND = 3'h5;
  localparam logic [2:0] SBSI_PH_STATUS = 3'h4;
  localparam logic [2:0] SBSI_PH_MSG_OUT = 3'h1;
  localparam logic [2:0] SBSI_PH_MSG_IN = 3'h0;
  localparam int SBSI_PH_MSG_BIT = 2;
  localparam int SBSI_PH_CD_BIT = 1;
  localparam int SBSI_PH_IO_BIT = 0;

  // Active-low lines: asserted level and released level.
  localparam logic SBSI_ASSERTED = 1'h0;
  localparam logic SBSI_RELEASED = 1'h1;

  // Transmission mode select levels.
  localparam logic SBSI_MODE_SINGLE = 1'h0;
  localparam logic SBSI_MODE_DIFF = 1'h1;

  // Byte geometry of the wide data bus.
  localparam int SBSI_BYTE_W = 8;
  localparam int SBSI_DATA_W = 16;

  // Link roles.
  typedef enum logic [1:0] {
    SBSI_ROLE_NONE,
    SBSI_ROLE_INIT,
    SBSI_ROLE_TARGET_ROLE_FLAG
  } sbsi_role_t;

  // Interlocked handshake states.
  typedef enum logic [1:0] {
    SBSI_HS_IDLE,
    SBSI_HS_WAIT_ASSERT,
    SBSI_HS_WAIT_NEGATE
  } sbsi_hs_t;

endpackage

// File: sbsi_byte_lane.sv
`timescale 1ns/1ps
`default_nettype none

// Registered drive of one data byte and its odd parity bit.
module sbsi_byte_lane
  import sbsi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic release_lane,
  input wire logic [7:0] byteIn,
  output logic [7:0] busByte,
  output logic busParity,
  output logic [8:0] driveEnable
);

  typedef struct packed {
    logic [7:0] data;
    logic par;
    logic drive;
  } sbsi_lane_t;

  sbsi_lane_t lane_reg;
  sbsi_lane_t lane_next;

  // Loads the byte; the parity bit makes the count of ones odd.
  always_comb
  begin
    lane_next = lane_reg;
    if (release_lane)
    begin
      lane_next.drive = 1'h0;
    end
    else if (load)
    begin
      lane_next.data = byteIn;
      lane_next.par = ~(^byteIn);
      lane_next.drive = 1'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lane_reg <= '0;
    end
    else
    begin
      lane_reg <= lane_next;
    end
  end

  // Lines are released high when not driven.
  assign busByte = lane_reg.drive ? ~lane_reg.data
                 : {SBSI_BYTE_W{SBSI_RELEASED}};
  assign busParity = lane_reg.drive ? ~lane_reg.par : SBSI_RELEASED;
  assign driveEnable = {9{lane_reg.drive}};

  chk_odd_parity: assert property (
    @(posedge core_clk) disable iff (rst)
    lane_reg.drive |-> ^{~busByte, ~busParity})
    else $error("Lane parity is not odd.");

  chk_lane_enable: assert property (
    @(posedge core_clk) disable iff (rst)
    (load && !release_lane) |=> (driveEnable == 9'h1ff))
    else $error("Lane enable did not follow load.");

endmodule
`default_nettype wire

// File: sbsi_far_device.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Far-side bus device
// ----------------------------------------------------------------

// Other device on the bus: initiator answering, or target sending.
module sbsi_far_device
  import sbsi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reqOut,
  input wire logic reqOe,
  input wire logic ackOut,
  input wire logic ackOe,
  input wire logic [15:0] dataBusOut,
  input wire logic sendStart,
  input wire logic [15:0] sendWord,
  input wire logic [3:0] lag,
  output logic reqIn,
  output logic ackIn,
  output logic [15:0] dataBusIn,
  output logic [15:0] seenWord
);
  int n;
  int m;

  // As initiator, acknowledge each request after a lag, interlocked.
  initial
  begin
    ackIn = SBSI_RELEASED;
    seenWord = 16'h0;
    forever
    begin
      @(posedge core_clk);
      if (reqOe === 1'h1 && reqOut === SBSI_ASSERTED)
      begin
        seenWord = ~dataBusOut;
        repeat (lag) @(posedge core_clk);
        #1 ackIn = SBSI_ASSERTED;
        for (n = 0; n < 40 && reqOe === 1'h1; n++)
          @(posedge core_clk);
        #1 ackIn = SBSI_RELEASED;
      end
    end
  end

  // As target, offer one word; lines return to the pulled-up level.
  initial
  begin
    reqIn = SBSI_RELEASED;
    dataBusIn = 16'hffff;
    forever
    begin
      @(posedge core_clk);
      if (sendStart === 1'h1)
      begin
        #1 dataBusIn = ~sendWord;
        @(posedge core_clk);
        #1 reqIn = SBSI_ASSERTED;
        for (m = 0; m < 40 && ackOut !== SBSI_ASSERTED; m++)
          @(posedge core_clk);
        #1 reqIn = SBSI_RELEASED;
        dataBusIn = 16'hffff;
        for (m = 0; m < 40 && ackOe === 1'h1; m++)
          @(posedge core_clk);
      end
    end
  end
endmodule

`default_nettype wire

// File: test_scsi_bus_signal_interface.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Bus signal layer bench
// ----------------------------------------------------------------

module test_scsi_bus_signal_interface
  import sbsi_pkg::*;
;
  logic core_clk = 1'h0;
  logic rst, arbitrate, selectStart, connectTarget, connectInit, disconnect;
  logic busResetReq, attentionReq, wordSend, sendStart;
  logic [2:0] phaseReq, phaseIn, phaseOut;
  logic [15:0] wordOut, wordIn, dataBusIn, dataBusOut, seenWord, sendWord;
  logic [15:0] data_bit_drive_enable;
  logic wordReady, wordDone, busResetSeen, modeDifferential;
  logic reqIn, ackIn, atnIn, bsyIn, selIn, rstIn, transmission_mode_select;
  logic reqOut, reqOe, ackOut, ackOe, atnOut, atnOe, phaseOe;
  logic bsyOut, busy_drive_enable, selOut, select_drive_enable, rstOut;
  logic bus_reset_drive_enable, upper_byte_parity, lower_byte_parity;
  logic upper_parity_drive_enable, lower_parity_drive_enable;
  logic initiator_role_flag, target_role_flag;
  logic [3:0] lag;
  int miscompares = 0;
  int totalChecks = 0;

  sbsi_core i_dut (
    .core_clk, .rst, .arbitrate, .selectStart, .connectTarget,
    .connectInit, .disconnect, .busResetReq, .attentionReq, .phaseReq,
    .wordSend, .wordOut, .wordReady, .wordDone, .wordIn, .busResetSeen,
    .modeDifferential, .reqIn, .ackIn, .atnIn, .phaseIn, .bsyIn, .selIn,
    .rstIn, .dataBusIn, .transmission_mode_select, .reqOut, .reqOe,
    .ackOut, .ackOe, .atnOut, .atnOe, .phaseOut, .phaseOe, .bsyOut,
    .busy_drive_enable, .selOut, .select_drive_enable, .rstOut,
    .bus_reset_drive_enable, .dataBusOut, .upper_byte_parity,
    .lower_byte_parity, .data_bit_drive_enable, .upper_parity_drive_enable,
    .lower_parity_drive_enable, .initiator_role_flag, .target_role_flag
  );

  sbsi_far_device i_far (
    .core_clk, .reqOut, .reqOe, .ackOut, .ackOe, .dataBusOut, .sendStart,
    .sendWord, .lag, .reqIn, .ackIn, .dataBusIn, .seenWord
  );

  // Free-running 10 MHz clock.
  always #50 core_clk = ~core_clk;

  // Advance to just after the next rising edge.
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  // Compare one bit and one word, counting every comparison.
  task automatic cmp_bit(input string what, input logic e, input logic g);
    totalChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic cmp_word(input string what, input logic [15:0] e,
    input logic [15:0] g);
    totalChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  // Print the verdict and stop.
  task automatic finish_test();
    if (miscompares == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Wait a bounded time for the end-of-word pulse.
  task automatic wait_done();
    int n;
    n = 0;
    while (wordDone !== 1'h1 && n < 40)
    begin
      tick();
      n++;
    end
    cmp_bit("wordDone", 1'h1, wordDone);
    if (wordDone !== 1'h1)
      finish_test();
  endtask

  // After reset every enable, flag and received word is clear.
  task automatic t_reset();
    cmp_word("enables", 16'h0, {busy_drive_enable, select_drive_enable,
      bus_reset_drive_enable, reqOe, ackOe, atnOe, phaseOe,
      upper_parity_drive_enable, lower_parity_drive_enable,
      initiator_role_flag, target_role_flag, 5'h0});
    cmp_word("dataOe", 16'h0, data_bit_drive_enable);
    cmp_word("wordIn", 16'h0, wordIn);
  endtask

  // Busy, select and reset lines follow their requests with enables.
  task automatic t_lines();
    logic [5:0] ctl;
    arbitrate = 1'h1;
    selectStart = 1'h1;
    busResetReq = 1'h1;
    tick();
    ctl = {bsyOut, busy_drive_enable, selOut, select_drive_enable, rstOut,
      bus_reset_drive_enable};
    cmp_word("ctlOn", 16'h15, {10'h0, ctl});
    arbitrate = 1'h0;
    selectStart = 1'h0;
    busResetReq = 1'h0;
    tick();
    ctl = {bsyOut, busy_drive_enable, selOut, select_drive_enable, rstOut,
      bus_reset_drive_enable};
    cmp_word("ctlOff", 16'h2a, {10'h0, ctl});
  endtask

  // Mode strap reaches the mode indication both ways.
  task automatic t_mode();
    transmission_mode_select = SBSI_MODE_DIFF;
    tick();
    cmp_bit("modeDiff", 1'h1, modeDifferential);
    transmission_mode_select = SBSI_MODE_SINGLE;
    tick();
    cmp_bit("modeSingle", 1'h0, modeDifferential);
  endtask

  // As target, every phase code appears on the phase lines.
  task automatic t_phases();
    logic [2:0] codes [6];
    logic [15:0] ph;
    codes = '{SBSI_PH_DATA_OUT, SBSI_PH_DATA_IN, SBSI_PH_COMMAND,
      SBSI_PH_STATUS, SBSI_PH_MSG_OUT, SBSI_PH_MSG_IN};
    connectTarget = 1'h1;
    tick();
    connectTarget = 1'h0;
    cmp_word("roleT", 16'h1, {14'h0, initiator_role_flag,
      target_role_flag});
    for (int i = 0; i < 6; i++)
    begin
      phaseReq = codes[i];
      tick();
      ph = {12'h0, phaseOe, phaseOut};
      cmp_word("phase", {13'h1, codes[i]}, ph);
    end
  endtask

  // As target, send one word with odd parity per byte.
  task automatic t_send(input logic [15:0] w, input logic [3:0] l);
    lag = l;
    phaseReq = SBSI_PH_DATA_IN;
    wordOut = w;
    tick();
    cmp_bit("wordReady", 1'h1, wordReady);
    wordSend = 1'h1;
    tick();
    wordSend = 1'h0;
    cmp_word("reqPar", {10'h0, SBSI_ASSERTED, 3'h7, ^w[15:8], ^w[7:0]},
      {10'h0, reqOut, reqOe, upper_parity_drive_enable,
      lower_parity_drive_enable, upper_byte_parity,
      lower_byte_parity});
    cmp_word("dataBus", ~w, dataBusOut);
    cmp_word("dataOe", 16'hffff, data_bit_drive_enable);
    wait_done();
    cmp_word("farWord", w, seenWord);
    // The lanes let go one cycle after the end-of-word pulse.
    tick();
    cmp_word("dataOeOff", 16'h0, data_bit_drive_enable);
  endtask

  // As initiator, raise attention and receive one word.
  task automatic t_recv(input logic [15:0] w);
    disconnect = 1'h1;
    tick();
    disconnect = 1'h0;
    connectInit = 1'h1;
    phaseIn = SBSI_PH_DATA_IN;
    attentionReq = 1'h1;
    tick();
    connectInit = 1'h0;
    tick();
    cmp_word("initAtn", {11'h0, SBSI_ASSERTED, 4'hc}, {11'h0, atnOut,
      atnOe, initiator_role_flag, target_role_flag, phaseOe});
    sendWord = w;
    sendStart = 1'h1;
    tick();
    sendStart = 1'h0;
    wait_done();
    cmp_word("wordIn", w, wordIn);
    cmp_word("dataOeIn", 16'h0, data_bit_drive_enable);
    cmp_word("ackOffIn", 16'h2, {14'h0, ackOut, ackOe});
    attentionReq = 1'h0;
  endtask

  // As initiator in an out phase, drive one word and answer the request.
  task automatic t_initout(input logic [15:0] w);
    phaseIn = SBSI_PH_DATA_OUT;
    wordOut = w;
    wordSend = 1'h1;
    tick();
    cmp_word("initBus", ~w, dataBusOut);
    cmp_word("initOe", 16'hffff, data_bit_drive_enable);
    sendStart = 1'h1;
    tick();
    sendStart = 1'h0;
    wait_done();
    cmp_word("ackOff", 16'h2, {14'h0, ackOut, ackOe});
    wordSend = 1'h0;
    tick();
    cmp_word("initOeOff", 16'h0, data_bit_drive_enable);
  endtask

  // A bus reset from outside is reported and drops the role.
  task automatic t_busreset();
    rstIn = SBSI_ASSERTED;
    tick();
    cmp_bit("resetSeen", 1'h1, busResetSeen);
    tick();
    cmp_word("roleNone", 16'h0, {14'h0, initiator_role_flag,
      target_role_flag});
    rstIn = SBSI_RELEASED;
  endtask

  // Main sequence.
  initial
  begin
    rst = 1'h1;
    {arbitrate, selectStart, connectTarget, connectInit, disconnect} = 5'h0;
    {busResetReq, attentionReq, wordSend, sendStart} = 4'h0;
    {phaseReq, phaseIn} = 6'h3f;
    {wordOut, sendWord, lag} = 36'h0;
    {atnIn, bsyIn, selIn, rstIn} = 4'hf;
    transmission_mode_select = SBSI_MODE_SINGLE;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'h0;
    t_reset();
    t_lines();
    t_mode();
    t_phases();
    t_send(16'h0000, 4'h0);
    t_send(16'h8001, 4'h3);
    t_recv(16'hc3a5);
    t_initout(16'h5a0f);
    t_busreset();
    finish_test();
  end
endmodule

`default_nettype wire
